// ---- rtl/skip_pkg.sv ----
// Purpose: Constants for the overflow/underflow interrupt skip block
// Assumes: AHB-Lite register slave, 32-bit word registers
// Notes: Register offsets are byte addresses
package skip_pkg;
    // --------------------------------------------------------------
    // Register offsets
    // --------------------------------------------------------------
    localparam logic [3:0] OFS_SETTING = 4'h0;
    localparam logic [3:0] OFS_STATUS = 4'h4;
    localparam logic [3:0] OFS_IRQ_STAT = 4'h8;
    localparam logic [3:0] OFS_IRQ_MASK = 4'hc;
    // --------------------------------------------------------------
    // Field positions
    // --------------------------------------------------------------
    localparam int SEL_LSB = 0;
    localparam int CNT_LSB = 4;
    localparam int LINK_A_BIT = 8;
    localparam int LINK_B_BIT = 9;
    localparam int EVMODE_BIT = 3;
    localparam int IRQ_OVF_BIT = 0;
    localparam int IRQ_UDF_BIT = 1;
    // --------------------------------------------------------------
    // Reset values
    // --------------------------------------------------------------
    localparam logic [1:0] SEL_RST = 2'h0;
    localparam logic [2:0] CNT_RST = 3'h0;
    localparam logic [1:0] MASK_RST = 2'h0;
    localparam logic [2:0] SKIP_ZERO = 3'h0;
    // --------------------------------------------------------------
    // Skip source select encodings
    // --------------------------------------------------------------
    typedef enum logic [1:0] {
        SRC_NONE = 2'b00,
        SRC_CREST = 2'b01,
        SRC_TROUGH = 2'b10,
        SRC_BOTH = 2'b11
    } skip_src_e;
endpackage

// ---- rtl/pwm_skip_ctrl.sv ----
// Purpose: Overflow/underflow interrupt skipping with linked A/D request gating
// Assumes: Timer event inputs are one-cycle pulses on clk_sys
// Notes: Zero-wait AHB-Lite slave; extended skip counters live elsewhere
//
// The AHB-Lite interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps

// What this block does
// R1: Source select 00 disables skipping, 01 counts crests, 10 troughs, 11 both, sawtooth always both.
// R2: The skip count runs 0 to 7 and zero means no skipping.
// R3: Separate link bits let A/D request A and B be skipped along with the interrupts.
// R4: While event count mode is active all skip settings are ignored.
// R5: The skip counter value is readable as a 3-bit status field.
// R6: With a nonzero source select the counter steps by one in each cycle that has a selected event.
// R7: The skip counter is held at zero while the main counter is stopped.
// R8: While skipping is active, a linked A/D request passes only while the skip counter is zero.
// R9: Skipping depends on the setting register, the timer modes and the counter run state, not on interrupt output enables.
// R10: This counter runs independently of the extended skip counters.
// R11: Software sets source select to 00 before changing the skip count.
// R12: Software should use an even count when counting both crests and troughs.
// R13: Software should check skipping state in sawtooth mode with direction changes.
// R14: A counted interrupt passes and clears the counter when the count is reached, else it is suppressed.
// R15: A zero count skips nothing and unlinked A/D requests are never gated.
module pwm_skip_ctrl (
    input wire logic clk_sys, // System clock, 20 MHz
    input wire logic srst, // Synchronous reset, active high
    input wire logic hsel, // AHB slave select
    input wire logic [31:0] haddr, // AHB address
    input wire logic [1:0] htrans, // AHB transfer type
    input wire logic hwrite, // AHB write
    input wire logic [2:0] hsize, // AHB size
    input wire logic [31:0] hwdata, // AHB write data
    input wire logic hready, // AHB bus ready
    output logic hreadyout, // AHB slave ready
    output logic hresp, // AHB response, always OKAY
    output logic [31:0] hrdata, // AHB read data
    input wire logic counter_running, // Main counter is counting
    input wire logic triangle_mode, // Triangle wave, else sawtooth
    input wire logic event_count_mode, // Any up/down count source bit set
    input wire logic ovf_event, // Overflow or crest pulse
    input wire logic udf_event, // Underflow or trough pulse
    input wire logic adc_req_a_in, // A/D start request A from timer
    input wire logic adc_req_b_in, // A/D start request B from timer
    output logic overflow_interrupt, // Passed overflow interrupt pulse
    output logic underflow_interrupt, // Passed underflow interrupt pulse
    output logic adc_req_a, // Gated A/D start request A
    output logic adc_req_b, // Gated A/D start request B
    output logic irq // Level interrupt, unmasked status set
);
    // --------------------------------------------------------------
    // Bus slave
    // --------------------------------------------------------------
    logic wr_pend_r;
    logic [3:0] wr_addr_r;
    logic [1:0] sel_r;
    logic [2:0] cnt_set_r;
    logic link_a_r;
    logic link_b_r;
    logic [1:0] mask_r;
    logic [1:0] stat_r;
    logic [2:0] skip_cnt_r;
    logic [2:0] skip_cnt_nxt;
    logic take;
    logic wr_setting;
    logic wr_stat;
    logic wr_mask;
    logic [31:0] rd_nxt;

    // Write data follows its address phase by one cycle, so the write is held over
    assign take = hsel && htrans[1] && hready;
    assign wr_setting = wr_pend_r && (wr_addr_r == skip_pkg::OFS_SETTING);
    assign wr_stat = wr_pend_r && (wr_addr_r == skip_pkg::OFS_IRQ_STAT);
    assign wr_mask = wr_pend_r && (wr_addr_r == skip_pkg::OFS_IRQ_MASK);

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 4'h0;
        end else begin
            wr_pend_r <= take && hwrite;
            wr_addr_r <= haddr[3:0];
        end
    end

    always_comb begin
        rd_nxt = 32'h0;
        case (haddr[3:0])
            skip_pkg::OFS_SETTING: begin
                rd_nxt[skip_pkg::SEL_LSB +: 2] = sel_r;
                rd_nxt[skip_pkg::CNT_LSB +: 3] = cnt_set_r;
                rd_nxt[skip_pkg::LINK_A_BIT] = link_a_r;
                rd_nxt[skip_pkg::LINK_B_BIT] = link_b_r;
            end
            skip_pkg::OFS_STATUS: begin
                rd_nxt[2:0] = skip_cnt_r; // R5
                rd_nxt[skip_pkg::EVMODE_BIT] = event_count_mode;
            end
            skip_pkg::OFS_IRQ_STAT: rd_nxt[1:0] = stat_r;
            skip_pkg::OFS_IRQ_MASK: rd_nxt[1:0] = mask_r;
            default: rd_nxt = 32'h0;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            hrdata <= 32'h0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            // Loaded at the address phase so it stands through the data phase
            if (take && !hwrite) begin
                hrdata <= rd_nxt;
            end
        end
    end

    // --------------------------------------------------------------
    // Skip setting register
    // --------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            sel_r <= skip_pkg::SEL_RST;
            cnt_set_r <= skip_pkg::CNT_RST;
            link_a_r <= 1'b0;
            link_b_r <= 1'b0;
        end else if (wr_setting) begin
            // A new count is only clean after the select has been released
            sel_r <= hwdata[skip_pkg::SEL_LSB +: 2]; // R1
            cnt_set_r <= hwdata[skip_pkg::CNT_LSB +: 3]; // R2
            link_a_r <= hwdata[skip_pkg::LINK_A_BIT]; // R3
            link_b_r <= hwdata[skip_pkg::LINK_B_BIT]; // R3
        end
    end

    // --------------------------------------------------------------
    // Event selection and skip counter
    // --------------------------------------------------------------
    logic active;
    logic ovf_counted;
    logic udf_counted;
    logic counted;
    logic reach;
    logic pass_ovf;
    logic pass_udf;

    // Only the setting register and mode steer skipping
    assign active = (sel_r != skip_pkg::SRC_NONE) && !event_count_mode; // R4 R9 R10
    assign ovf_counted = active && ovf_event && (!triangle_mode || sel_r[0]); // R1
    assign udf_counted = active && udf_event && (!triangle_mode || sel_r[1]); // R1
    assign counted = ovf_counted || udf_counted;
    assign reach = skip_cnt_r == cnt_set_r;
    assign pass_ovf = ovf_event && (!ovf_counted || reach); // R14 R15
    assign pass_udf = udf_event && (!udf_counted || reach); // R14 R15

    always_comb begin
        skip_cnt_nxt = skip_cnt_r;
        if (!counter_running) begin
            skip_cnt_nxt = skip_pkg::SKIP_ZERO; // R7
        end else if (sel_r == skip_pkg::SRC_NONE) begin
            // A released select restarts the count, so a zero count never skips
            skip_cnt_nxt = skip_pkg::SKIP_ZERO; // R2
        end else if (counted) begin
            if (reach) begin
                skip_cnt_nxt = skip_pkg::SKIP_ZERO; // R14
            end else begin
                skip_cnt_nxt = skip_cnt_r + 3'h1; // R6
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            skip_cnt_r <= skip_pkg::SKIP_ZERO;
        end else begin
            skip_cnt_r <= skip_cnt_nxt;
        end
    end

    // --------------------------------------------------------------
    // Gated outputs
    // --------------------------------------------------------------
    logic open_gate;
    assign open_gate = skip_cnt_r == skip_pkg::SKIP_ZERO;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            overflow_interrupt <= 1'b0;
            underflow_interrupt <= 1'b0;
        end else begin
            overflow_interrupt <= pass_ovf;
            underflow_interrupt <= pass_udf;
        end
    end

    // --------------------------------------------------------------
    // Gated A/D start requests, one lane per request
    // --------------------------------------------------------------
    logic [1:0] req_in;
    logic [1:0] req_link;
    logic [1:0] req_q;

    assign req_in = {adc_req_b_in, adc_req_a_in};
    assign req_link = {link_b_r, link_a_r}; // R3
    assign adc_req_a = req_q[0];
    assign adc_req_b = req_q[1];

    for (genvar g = 0; g < 2; g++) begin : g_req
        // The gate looks at the count as it stood when the request came in
        always_ff @(posedge clk_sys) begin
            if (srst) begin
                req_q[g] <= 1'b0;
            end else begin
                req_q[g] <= req_in[g] && (!req_link[g] || !active || open_gate); // R8 R15
            end
        end
    end

    // --------------------------------------------------------------
    // Interrupt status and mask
    // --------------------------------------------------------------
    logic [1:0] ev_set;
    always_comb begin
        ev_set = 2'h0;
        ev_set[skip_pkg::IRQ_OVF_BIT] = pass_ovf;
        ev_set[skip_pkg::IRQ_UDF_BIT] = pass_udf;
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            stat_r <= 2'h0;
            mask_r <= skip_pkg::MASK_RST;
            irq <= 1'b0;
        end else begin
            // Set wins over a write-one clear in the same cycle
            stat_r <= (stat_r & ~(wr_stat ? hwdata[1:0] : 2'h0)) | ev_set;
            if (wr_mask) begin
                mask_r <= hwdata[1:0];
            end
            irq <= |(((stat_r & ~(wr_stat ? hwdata[1:0] : 2'h0)) | ev_set) & mask_r);
        end
    end

    // --------------------------------------------------------------
    // Assertions
    // --------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    a_stop_clears: assert property (!counter_running |=> skip_cnt_r == 3'h0) // R7
        else $error("skip counter not zero while stopped");
    a_release_clr: assert property (sel_r == skip_pkg::SRC_NONE |=> skip_cnt_r == 3'h0) // R2
        else $error("released select left the count standing");
    a_count_step: assert property (counter_running && counted && !reach // R6
        |=> skip_cnt_r == $past(skip_cnt_r) + 3'h1)
        else $error("skip counter did not step");
    a_reach_wrap: assert property (counter_running && counted && reach // R14
        |=> skip_cnt_r == 3'h0 && overflow_interrupt == $past(ovf_event))
        else $error("reach did not pass and clear");
    a_skip_ovf: assert property (ovf_counted && !reach |=> !overflow_interrupt) // R14
        else $error("skipped overflow interrupt leaked");
    a_skip_udf: assert property (udf_counted && !reach |=> !underflow_interrupt) // R14
        else $error("skipped underflow interrupt leaked");
    a_zero_nskip: assert property (cnt_set_r == 3'h0 && !wr_setting && ovf_event // R2 R15
        |=> overflow_interrupt)
        else $error("zero count skipped an interrupt");
    a_link_gate: assert property (adc_req_a_in && link_a_r && active && !open_gate // R8
        |=> !adc_req_a)
        else $error("linked request A not blocked");
    a_link_gate_b: assert property (adc_req_b_in && link_b_r && active && !open_gate // R8
        |=> !adc_req_b)
        else $error("linked request B not blocked");
    a_open_pass: assert property (adc_req_a_in && open_gate |=> adc_req_a) // R8
        else $error("request A blocked with the counter at zero");
    a_unlinked: assert property (adc_req_b_in && !link_b_r |=> adc_req_b) // R15
        else $error("unlinked request B gated");
    a_unlinked_a: assert property (adc_req_a_in && !link_a_r |=> adc_req_a) // R15
        else $error("unlinked request A gated");
    a_evmode_off: assert property (event_count_mode && udf_event |=> underflow_interrupt) // R4
        else $error("skipping active in event count mode");
    a_evmode_hold: assert property (event_count_mode && counter_running // R4
        && sel_r != skip_pkg::SRC_NONE |=> $stable(skip_cnt_r))
        else $error("counter moved in event count mode");
    a_held_idle: assert property (counter_running && !counted && $stable(counter_running) // R6
        && sel_r != skip_pkg::SRC_NONE |=> $stable(skip_cnt_r))
        else $error("counter moved without event");
    a_crest_only: assert property (triangle_mode && sel_r == skip_pkg::SRC_CREST // R1
        && udf_event && !event_count_mode |=> underflow_interrupt)
        else $error("trough counted with crest select");
    a_read_count: assert property (take && !hwrite && haddr[3:0] == skip_pkg::OFS_STATUS // R5
        |=> hrdata[2:0] == $past(skip_cnt_r))
        else $error("status read lost the skip count");
    a_setting_ld: assert property (wr_setting |=> // R3
        link_a_r == $past(hwdata[skip_pkg::LINK_A_BIT])
        && link_b_r == $past(hwdata[skip_pkg::LINK_B_BIT]))
        else $error("link bits not taken from the write");
    a_ovf_stat: assert property (pass_ovf |=> stat_r[skip_pkg::IRQ_OVF_BIT]) // R14
        else $error("passed overflow not recorded");
    a_udf_stat: assert property (pass_udf |=> stat_r[skip_pkg::IRQ_UDF_BIT]) // R14
        else $error("passed underflow not recorded");

    // Main scenarios
    c_skip: cover property (ovf_counted && !reach ##1 !overflow_interrupt);
    c_skip_udf: cover property (udf_counted && !reach ##1 !underflow_interrupt);
    c_wrap: cover property (counted && reach && cnt_set_r == 3'h2);
    c_gate_a: cover property (adc_req_a_in && link_a_r && !open_gate);
    c_irq: cover property (irq);
endmodule // pwm_skip_ctrl

// ---- sim/skip_partner.sv ----
// Purpose: A/D trigger input and interrupt controller stand-in
// Assumes: Requests and interrupts arrive as one-cycle pulses
// Notes: Counts every pulse it accepts
`timescale 1ns/1ps
module skip_partner (
    input wire logic clk_sys, // System clock
    input wire logic srst, // Sync reset
    input wire logic ovf_in, // Overflow interrupt
    input wire logic udf_in, // Underflow interrupt
    input wire logic adc_a_in, // A/D trigger A
    input wire logic adc_b_in, // A/D trigger B
    output int pulse_cnt // Pulses accepted
);
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            pulse_cnt <= 0;
        end else begin
            pulse_cnt <= pulse_cnt + ovf_in + udf_in + adc_a_in + adc_b_in;
        end
    end
endmodule // skip_partner

// ---- sim/pwm_timer_interrupt_skip_adc_link_tb.sv ----
// Purpose: Self-checking bench for the interrupt skip block
// Assumes: Zero-wait AHB-Lite slave, one clock
// Notes: Cycle model runs beside the design on random events
`timescale 1ns/1ps
module pwm_timer_interrupt_skip_adc_link_tb;
    logic clk_sys, srst, hwrite, run, tri_m, ecm, ovf, udf, ada, adb, rnd, live;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans, sel_m, stat_m;
    logic [2:0] cnt_m, skip_m, cnt_k;
    logic hreadyout, hresp, o_ovf, o_udf, o_ada, o_adb, irq, la_m, lb_m;
    logic e_ovf, e_udf, e_ada, e_adb, cov, cud, act;
    wire hready = hreadyout;
    int error_cnt, checks_done, seed, exp_pulses, pc, i;
    pwm_skip_ctrl uut (.clk_sys(clk_sys), .srst(srst), .hsel(1'b1), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .counter_running(run),
        .triangle_mode(tri_m), .event_count_mode(ecm), .ovf_event(ovf), .udf_event(udf),
        .adc_req_a_in(ada), .adc_req_b_in(adb), .overflow_interrupt(o_ovf),
        .underflow_interrupt(o_udf), .adc_req_a(o_ada), .adc_req_b(o_adb), .irq(irq));
    skip_partner far (.clk_sys(clk_sys), .srst(srst), .ovf_in(o_ovf), .udf_in(o_udf),
        .adc_a_in(o_ada), .adc_b_in(o_adb), .pulse_cnt(pc));
    initial begin
        clk_sys = 0;
        forever #25 clk_sys = ~clk_sys;
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", nm, e, g);
        end
    endtask
    task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        @(posedge clk_sys);
        while (hready !== 1'b1) @(posedge clk_sys);
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge clk_sys);
        while (hready !== 1'b1) @(posedge clk_sys);
        rd = hrdata;
        chk("hresp", 32'h0, hresp);
    endtask
    task automatic cfg(input logic [1:0] s, input logic [2:0] k, input logic a, input logic b);
        ahb(1, 32'h0, 32'h0);
        sel_m <= 2'h0;
        run <= 0;
        @(posedge clk_sys);
        run <= 1;
        ahb(0, 32'h4, 0);
        chk("skip_counter_value", {28'h0, ecm, 3'h0}, rd);
        ahb(1, 32'h0, {22'h0, b, a, 1'b0, k, 2'h0, s});
        {lb_m, la_m, skip_m, sel_m} <= {b, a, k, s};
    endtask
    task automatic give_verdict();
        $display("checks %0d, errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // Reference model and per-cycle comparison
    // ------------------------------------------------------------
    always @(posedge clk_sys) begin
        act = sel_m != 2'h0 && !ecm;
        cov = act && ovf && (!tri_m || sel_m[0]);
        cud = act && udf && (!tri_m || sel_m[1]);
        e_ovf = !srst && ovf && (!cov || cnt_m == skip_m);
        e_udf = !srst && udf && (!cud || cnt_m == skip_m);
        e_ada = !srst && ada && !(la_m && act && cnt_m != 3'h0);
        e_adb = !srst && adb && !(lb_m && act && cnt_m != 3'h0);
        exp_pulses += e_ovf + e_udf + e_ada + e_adb;
        stat_m = stat_m | {e_udf, e_ovf};
        if (srst || !run || sel_m == 2'h0) cnt_m = 3'h0;
        else if (cov || cud) cnt_m = (cnt_m == skip_m) ? 3'h0 : cnt_m + 3'h1;
    end
    always @(negedge clk_sys) begin
        if (live) begin
            chk("overflow_interrupt", e_ovf, o_ovf);
            chk("underflow_interrupt", e_udf, o_udf);
            chk("adc_req_a", e_ada, o_ada);
            chk("adc_req_b", e_adb, o_adb);
        end
    end
    always @(posedge clk_sys) begin
        ovf <= rnd && ($random(seed) & 3) == 0;
        udf <= rnd && ($random(seed) & 3) == 0;
        ada <= rnd && ($random(seed) & 1) == 0;
        adb <= rnd && ($random(seed) & 1) == 0;
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        seed = 32'hdb1ee841;
        {srst, run, tri_m, ecm, rnd, live, hwrite} = 7'b1100000;
        {haddr, hwdata, htrans} = '0;
        {sel_m, stat_m, cnt_m, skip_m, la_m, lb_m} = '0;
        {e_ovf, e_udf, e_ada, e_adb} = '0;
        repeat (20) @(posedge clk_sys);
        srst <= 0;
        @(posedge clk_sys);
        live = 1;
        ahb(0, 32'h0, 0);
        chk("setting_reset", 0, rd);
        for (i = 0; i < 24; i++) begin
            tri_m <= i[2];
            ecm <= (i % 7) == 6;
            cnt_k = (i < 8) ? i[2:0] : 3'($random(seed));
            if (i >= 8 && i[2] && i[1:0] == 2'h3) cnt_k[0] = 1'b0;
            cfg(i[1:0], cnt_k, 1'($random(seed)), i[3]);
            rnd <= 1;
            repeat (150) @(posedge clk_sys);
            rnd <= 0;
            repeat (3) @(posedge clk_sys);
            ahb(0, 32'h4, 0);
            chk("skip_counter_value", {28'h0, ecm, cnt_m}, rd);
        end
        ahb(0, 32'h8, 0);
        chk("irq_status", {30'h0, stat_m}, rd);
        chk("irq_masked", 1'b0, irq);
        ahb(1, 32'hc, 32'h3);
        repeat (2) @(posedge clk_sys);
        chk("irq_unmasked", |stat_m, irq);
        ahb(1, 32'h8, 32'h3);
        stat_m = 2'h0;
        repeat (2) @(posedge clk_sys);
        chk("irq_cleared", 1'b0, irq);
        ahb(0, 32'h8, 0);
        chk("irq_status_cleared", 0, rd);
        repeat (3) @(posedge clk_sys);
        chk("partner_pulses", exp_pulses, pc);
        give_verdict();
    end
    initial begin
        #1000000;
        error_cnt++;
        give_verdict();
    end
endmodule // pwm_timer_interrupt_skip_adc_link_tb
